// ===== src/sync_serial_txrx.sv
// Full-duplex synchronous serial port: stop control, underrun and overrun handling.
// Assumes the peer drives the serial clock; clk and the serial clock are unrelated.
`timescale 1ns/1ps
`default_nettype none

module sync_serial_txrx
	import serial_txrx_pkg::*;
#(
	parameter int BUF_DEPTH = 2
)(
	// System clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control register access
	input wire logic ctlWrite,
	input wire ctrl_s ctlIn,
	input wire logic ctlInhibit,
	output ctrl_s ctrlOut,
	output status_s statusOut,
	// Transmit buffer write side
	input wire logic [DATA_BITS-1:0] txData,
	input wire logic txValid,
	output logic txReady,
	// Receive buffer read side
	input wire logic rxRead,
	output logic [DATA_BITS-1:0] rxData,
	output logic rxDataValid,
	// Interrupt request
	output logic serialIrq,
	// Serial link
	input wire logic serialClock,
	input wire logic serialDataIn,
	output logic serialDataOut
);

	// Elaboration check: pointers need at least one bit, bytes are fixed at eight
	if (BUF_DEPTH < 2 || DATA_BITS != 8)
	begin : g_bad_param
		$error("Buffer depth must be at least two and bytes eight bits");
	end

	// System side state
	ctrl_s ctrl; // Control register
	logic shiftActive, shiftInProgress, txUnderrun, rxOverrun, rxFull;
	logic txEmpty; // Nothing waiting to be sent
	logic [7:0] rxBuf; // Last good received byte
	logic [7:0] errWord; // Shift contents at overrun
	logic errStage; // First read after overrun done
	logic [7:0] txHold; // Word offered to the link
	logic txTog; // Toggles when txHold is refreshed
	logic abortTog; // Toggles on each forced stop
	logic inhibit; // Forced stop this cycle
	// Link to system crossings
	logic ackS1, ackS2, startS1, startS2, startS3, doneS1, doneS2, doneS3;
	logic abortAckS1, abortAckS2; // Last forced stop as seen by the link
	logic startEv, doneEv, holdFree, abortPend;
	// Link side state
	logic [3:0] bitCnt; // Falling edges seen in this byte
	logic [7:0] txShift;
	logic soReg, under, linkStartTg, txAck, abortSeen;
	logic runS1, runS2, txTogS1, txTogS2, abortS1, abortS2, rstS1, rstS2;
	logic [2:0] rxCnt;
	logic [7:0] rxShift, rxWord;
	logic linkDoneTg;
	// BUF_DEPTH-entry transmit buffer
	logic [7:0] bufMem [BUF_DEPTH];
	logic [$clog2(BUF_DEPTH+1)-1:0] bufCnt;
	logic [$clog2(BUF_DEPTH)-1:0] wrPtr, rdPtr;
	logic bufPush, bufPop, bufEmpty;

	assign inhibit = ctlWrite && ctlInhibit;
	assign ctrlOut = ctrl;
	assign statusOut = '{shiftActive: shiftActive, shiftInProgress: shiftInProgress,
		txUnderrun: txUnderrun, rxOverrun: rxOverrun, rxFull: rxFull, txEmpty: txEmpty};
	assign serialDataOut = soReg;

	// Control register: inhibit wins over a plain write
	always_ff @(posedge clk)
	begin
		if (rst)
			ctrl <= CTRL_RESET;
		else if (inhibit)
			ctrl <= '{opMode: ctrl.opMode, start: 1'b0};
		else if (ctlWrite)
			ctrl <= ctlIn;
	end

	// Forced stop reaches the link as a toggle
	always_ff @(posedge clk)
	begin
		if (rst)
			abortTog <= 1'b0;
		else if (inhibit)
			abortTog <= ~abortTog;
	end

	// Events back from the link, third stage only for edge detection
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ackS1 <= 1'b0;
			ackS2 <= 1'b0;
			startS1 <= 1'b0;
			startS2 <= 1'b0;
			startS3 <= 1'b0;
			doneS1 <= 1'b0;
			doneS2 <= 1'b0;
			doneS3 <= 1'b0;
			abortAckS1 <= 1'b0;
			abortAckS2 <= 1'b0;
		end
		else
		begin
			ackS1 <= txAck;
			ackS2 <= ackS1;
			startS1 <= linkStartTg;
			startS2 <= startS1;
			startS3 <= startS2;
			doneS1 <= linkDoneTg;
			doneS2 <= doneS1;
			doneS3 <= doneS2;
			abortAckS1 <= abortSeen;
			abortAckS2 <= abortAckS1;
		end
	end

	// A stopped link clock leaves stale run samples for the next frame's first edges;
	// link events are dropped until the link has taken the last forced stop
	assign abortPend = (abortTog != abortAckS2);
	assign startEv = (startS2 ^ startS3) && !abortPend;
	assign doneEv = (doneS2 ^ doneS3) && !abortPend;
	assign holdFree = (txTog == ackS2);

	// Transmit buffer: stalls the writer when all BUF_DEPTH entries hold data
	assign bufEmpty = (bufCnt == '0);
	assign txReady = (bufCnt != BUF_DEPTH[$bits(bufCnt)-1:0]) && !inhibit;
	assign bufPush = txValid && txReady;
	assign bufPop = !bufEmpty && holdFree && !inhibit;

	always_ff @(posedge clk)
	begin
		if (rst || inhibit)
		begin
			bufCnt <= '0;
			wrPtr <= '0;
			rdPtr <= '0;
		end
		else
		begin
			bufCnt <= bufCnt + $bits(bufCnt)'(bufPush) - $bits(bufCnt)'(bufPop);
			if (bufPush)
				wrPtr <= (wrPtr == $bits(wrPtr)'(BUF_DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			if (bufPop)
				rdPtr <= (rdPtr == $bits(rdPtr)'(BUF_DEPTH - 1)) ? '0 : rdPtr + 1'b1;
		end
	end

	// Buffer storage, one generate branch per entry
	for (genvar i = 0; i < BUF_DEPTH; i++)
	begin : g_buf
		always_ff @(posedge clk)
		begin
			if (rst)
				bufMem[i] <= DATA_RESET;
			else if (bufPush && wrPtr == $bits(wrPtr)'(i))
				bufMem[i] <= txData;
		end
	end

	// Hand the next word to the link; abort drops a word not yet taken
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			txHold <= DATA_RESET;
			txTog <= 1'b0;
		end
		else if (inhibit)
		begin
			txHold <= DATA_RESET;
			txTog <= ackS2;
		end
		else if (bufPop)
		begin
			txHold <= bufMem[rdPtr];
			txTog <= ~txTog;
		end
	end

	// Empty flag: a write clears it, set again once the link takes the word
	always_ff @(posedge clk)
	begin
		if (rst || inhibit)
			txEmpty <= 1'b1;
		else
			txEmpty <= !bufPush && bufEmpty && holdFree;
	end

	// Activity flags follow the link's byte boundaries
	always_ff @(posedge clk)
	begin
		if (rst || inhibit)
		begin
			shiftActive <= 1'b0;
			shiftInProgress <= 1'b0;
		end
		else if (startEv)
		begin
			shiftActive <= 1'b1;
			shiftInProgress <= 1'b1;
		end
		else if (doneEv)
		begin
			shiftInProgress <= 1'b0;
			if (!ctrl.start)
				shiftActive <= 1'b0;
		end
	end

	// Underrun is sticky until a forced stop
	always_ff @(posedge clk)
	begin
		if (rst || inhibit)
			txUnderrun <= 1'b0;
		else if (startEv && under)
			txUnderrun <= 1'b1;
	end

	// Receive path: a new byte beats a read in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst || inhibit)
		begin
			rxBuf <= DATA_RESET;
			errWord <= DATA_RESET;
			rxFull <= 1'b0;
			rxOverrun <= 1'b0;
			errStage <= 1'b0;
		end
		else
		begin
			if (rxRead && rxOverrun && errStage)
			begin
				rxOverrun <= 1'b0;
				errStage <= 1'b0;
				rxFull <= 1'b0;
			end
			else if (rxRead && rxOverrun)
				errStage <= 1'b1;
			else if (rxRead && !doneEv)
				rxFull <= 1'b0;
			if (doneEv && !rxOverrun)
			begin
				if (rxFull && !(rxRead && !rxOverrun))
				begin
					rxOverrun <= 1'b1;
					errWord <= rxWord;
				end
				else
				begin
					rxBuf <= rxWord;
					rxFull <= 1'b1;
				end
			end
		end
	end

	// Read data: good byte first, then the word caught at the overrun
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rxData <= DATA_RESET;
			rxDataValid <= 1'b0;
		end
		else
		begin
			rxDataValid <= rxRead;
			if (rxRead)
				rxData <= (rxOverrun && errStage) ? errWord : rxBuf;
		end
	end

	// One interrupt per finished byte; silent while overrun stands
	always_ff @(posedge clk)
	begin
		if (rst || inhibit)
			serialIrq <= 1'b0;
		else
			serialIrq <= doneEv && !rxOverrun;
	end

	// Link-side synchronisers; the clock only runs inside frames
	always_ff @(negedge serialClock)
	begin
		rstS1 <= rst;
		rstS2 <= rstS1;
		runS1 <= ctrl.start && (ctrl.opMode == MODE_TXRX);
		runS2 <= runS1;
		txTogS1 <= txTog;
		txTogS2 <= txTogS1;
		abortS1 <= abortTog;
		abortS2 <= abortS1;
	end

	// Transmit shifter on falling edges
	always_ff @(negedge serialClock)
	begin
		if (rstS2)
		begin
			bitCnt <= BIT_IDLE;
			txShift <= DATA_RESET;
			soReg <= LINE_IDLE;
			under <= 1'b0;
			linkStartTg <= 1'b0;
			txAck <= 1'b0;
			abortSeen <= 1'b0;
		end
		else if (abortS2 != abortSeen)
		begin
			abortSeen <= abortS2;
			bitCnt <= BIT_IDLE;
			under <= 1'b0;
			soReg <= LINE_IDLE;
		end
		else if ((bitCnt == BIT_IDLE || bitCnt == BIT_LAST) && runS2)
		begin
			bitCnt <= BIT_FIRST;
			linkStartTg <= ~linkStartTg;
			if (txTogS2 != txAck && !under)
			begin
				txShift <= {txHold[6:0], 1'b0};
				soReg <= txHold[7];
				txAck <= txTogS2;
			end
			else
			begin
				under <= 1'b1;
				soReg <= LINE_IDLE;
			end
		end
		else if (bitCnt == BIT_LAST)
		begin
			bitCnt <= BIT_IDLE;
			soReg <= LINE_IDLE;
		end
		else if (bitCnt != BIT_IDLE)
		begin
			bitCnt <= bitCnt + BIT_FIRST;
			soReg <= under ? LINE_IDLE : txShift[7];
			txShift <= {txShift[6:0], 1'b0};
		end
	end

	// Receive shifter on rising edges; eighth bit completes the byte
	always_ff @(posedge serialClock)
	begin
		if (rstS2 || bitCnt == BIT_IDLE)
		begin
			rxCnt <= '0;
			if (rstS2)
			begin
				rxShift <= DATA_RESET;
				rxWord <= DATA_RESET;
				linkDoneTg <= 1'b0;
			end
		end
		else
		begin
			rxShift <= {rxShift[6:0], serialDataIn};
			if (rxCnt == RX_LAST)
			begin
				rxWord <= {rxShift[6:0], serialDataIn};
				linkDoneTg <= ~linkDoneTg;
				rxCnt <= '0;
			end
			else
				rxCnt <= rxCnt + 1'b1;
		end
	end

	// Checks on the system side
	sequence s_err_read;
		rxRead && rxOverrun && errStage;
	endsequence

	sequence s_inhibit;
		ctlWrite && ctlInhibit;
	endsequence

	a_inhibit_init: assert property (@(posedge clk) disable iff (rst)
		s_inhibit |=> !ctrl.start && !rxFull && !rxOverrun && !txUnderrun && txEmpty
			&& !shiftActive && rxBuf == DATA_RESET)
		else $error("Forced stop did not initialise state");

	a_underrun_set: assert property (@(posedge clk) disable iff (rst)
		startEv && under && !inhibit |=> txUnderrun)
		else $error("Underrun not flagged at shift start");

	a_underrun_hold: assert property (@(posedge clk) disable iff (rst)
		txUnderrun && !inhibit |=> txUnderrun)
		else $error("Underrun flag dropped without forced stop");

	a_overrun_set: assert property (@(posedge clk) disable iff (rst)
		doneEv && rxFull && !rxOverrun && !rxRead && !inhibit |=> rxOverrun
			&& errWord == $past(rxWord))
		else $error("Overrun not flagged on full buffer");

	a_overrun_freeze: assert property (@(posedge clk) disable iff (rst)
		rxOverrun && !inhibit ##1 rxOverrun |-> $stable(rxBuf) && $stable(errWord))
		else $error("Buffer changed during overrun");

	a_err_read_clear: assert property (@(posedge clk) disable iff (rst)
		s_err_read and !inhibit |=> !rxOverrun && !rxFull ##0 rxDataValid
			&& rxData == $past(errWord))
		else $error("Second read did not return captured word");

	a_irq_silent: assert property (@(posedge clk) disable iff (rst)
		rxOverrun ##1 rxOverrun |-> !serialIrq)
		else $error("Interrupt raised during overrun");

	a_irq_pulse: assert property (@(posedge clk) disable iff (rst)
		doneEv && !rxOverrun && !inhibit |=> serialIrq ##1 !serialIrq)
		else $error("Byte completion interrupt not a single pulse");

	a_stop_clear: assert property (@(posedge clk) disable iff (rst)
		doneEv && !startEv && !ctrl.start && !inhibit |=> !shiftActive && !shiftInProgress)
		else $error("Active flag not cleared at stop");

	a_progress_flag: assert property (@(posedge clk) disable iff (rst)
		startEv && !inhibit |=> shiftInProgress && shiftActive)
		else $error("In-progress flag not raised at byte start");

endmodule

`default_nettype wire

// ===== src/serial_txrx_pkg.sv
// Constants and carrier types for the synchronous serial transmit/receive port.
// Assumes one 8-bit data path and an externally clocked serial link.
package serial_txrx_pkg;

	// Byte size on the serial link
	localparam int DATA_BITS = 8;
	// Operating mode that enables full-duplex transfer
	localparam logic [1:0] MODE_TXRX = 2'h2;
	// Bit counter values on the link side
	localparam logic [3:0] BIT_IDLE = 4'h0;
	localparam logic [3:0] BIT_FIRST = 4'h1;
	localparam logic [3:0] BIT_LAST = 4'h8;
	// Receive counter value at the final bit
	localparam logic [2:0] RX_LAST = 3'h7;
	// Reset values
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic LINE_IDLE = 1'b1;
	localparam logic [1:0] MODE_RESET = 2'h0;

	// Software control word
	typedef struct packed {
		logic [1:0] opMode;
		logic start;
	} ctrl_s;

	// Status word shown to software
	typedef struct packed {
		logic shiftActive;
		logic shiftInProgress;
		logic txUnderrun;
		logic rxOverrun;
		logic rxFull;
		logic txEmpty;
	} status_s;

	localparam ctrl_s CTRL_RESET = '{opMode: MODE_RESET, start: 1'b0};

endpackage

// ===== tb/serial_peer.sv
// Model of the external peer: it makes the link clock and the data in.
// Assumes go rises once per frame and stays high until done.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
	// Frame request
	input wire logic go,
	input wire logic [3:0] pre,
	input wire logic [7:0] sendByte,
	output logic [7:0] gotByte,
	output logic done,
	// Link pins
	output logic sck,
	output logic sdi,
	input wire logic sdo
);
	// Clock stands high between frames
	initial
	begin
		sck = 1'b1;
		sdi = 1'b0;
		done = 1'b1;
		gotByte = 8'h00;
	end
	// Lead-in edges, then eight bits MSB first
	always @(posedge go)
	begin
		done = 1'b0;
		for (int i = 0; i < pre + 8; i++)
		begin
			sck = 1'b0;
			// Lead-in bits toggle: nothing is promised there
			sdi = (i < pre) ? ~sdi : sendByte[7 + pre - i];
			#15 sck = 1'b1;
			gotByte = {gotByte[6:0], sdo};
			#15;
		end
		// Hold time over: keep the line moving
		sdi = ~sdi;
		done = 1'b1;
	end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench: stop, inhibit, underrun and overrun of the serial port.
// Assumes serial_peer drives the link; the link clock is 30 ns inside frames.
`timescale 1ns/1ps
`default_nettype none
module tb
	import serial_txrx_pkg::*;
;
	// Design ports
	logic clk, rst, ctlWrite, ctlInhibit, txValid, txReady, rxRead, rxDataValid;
	logic serialIrq, sck, sdi, sdo, go, done;
	ctrl_s ctlIn, ctrlOut;
	status_s statusOut;
	logic [7:0] txData, rxData, sendByte, gotByte;
	logic [3:0] pre;
	// Scoreboard
	int errTotal = 0;
	int checkCount = 0;
	logic [7:0] irqCnt = 8'h00;
	logic [7:0] irqEv = 8'h00;
	logic irqLast = 1'b0;

	sync_serial_txrx #(.BUF_DEPTH(2)) dut_u (.clk(clk), .rst(rst), .ctlWrite(ctlWrite),
		.ctlIn(ctlIn), .ctlInhibit(ctlInhibit), .ctrlOut(ctrlOut), .statusOut(statusOut),
		.txData(txData), .txValid(txValid), .txReady(txReady), .rxRead(rxRead),
		.rxData(rxData), .rxDataValid(rxDataValid), .serialIrq(serialIrq),
		.serialClock(sck), .serialDataIn(sdi), .serialDataOut(sdo));
	serial_peer peer_u (.go(go), .pre(pre), .sendByte(sendByte), .gotByte(gotByte),
		.done(done), .sck(sck), .sdi(sdi), .sdo(sdo));

	// 20 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// High cycles and rising edges of the interrupt; equal counts mean 1-cycle pulses
	always @(posedge clk)
	begin
		if (serialIrq === 1'b1)
			irqCnt <= irqCnt + 8'h01;
		if (serialIrq === 1'b1 && irqLast !== 1'b1)
			irqEv <= irqEv + 8'h01;
		irqLast <= serialIrq;
	end

	task automatic tick;
		@(posedge clk);
		#2;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Control write; a trailing idle cycle keeps strobes apart
	task automatic ctl(input logic [1:0] m, input logic s, input logic inh);
		ctlWrite = 1'b1;
		ctlIn = '{opMode: m, start: s};
		ctlInhibit = inh;
		tick;
		ctlWrite = 1'b0;
		ctlInhibit = 1'b0;
		tick;
	endtask
	task automatic put(input logic [7:0] d);
		txValid = 1'b1;
		txData = d;
		tick;
		txValid = 1'b0;
		tick;
	endtask
	task automatic get(input logic [7:0] e);
		rxRead = 1'b1;
		tick;
		rxRead = 1'b0;
		chk("rxValid", 8'(rxDataValid), 8'h01);
		chk("rxData", rxData, e);
		tick;
	endtask
	task automatic kick(input logic [3:0] p, input logic [7:0] b);
		pre = p;
		sendByte = b;
		go = 1'b1;
		// Peer lowers done in this same step; keeps stimulus on the usual offset
		wait (done === 1'b0);
	endtask
	// Crossings settle within a few cycles of the last edge
	task automatic finish;
		wait (done === 1'b1);
		go = 1'b0;
		repeat (8) tick;
	endtask
	task automatic completeRun;
		$display("checks %0d errors %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Cuts a hang short
	initial
	begin
		#200000;
		errTotal++;
		completeRun;
	end

	initial
	begin
		rst = 1'b1;
		ctlWrite = 1'b0;
		ctlIn = CTRL_RESET;
		ctlInhibit = 1'b0;
		txData = 8'h00;
		txValid = 1'b0;
		rxRead = 1'b0;
		go = 1'b0;
		pre = 4'h0;
		sendByte = 8'h00;
		// Link edges during reset reach the link side
		tick;
		kick(4'h4, 8'h00);
		repeat (2) tick;
		rst = 1'b0;
		finish;
		chk("ctrl", 8'(ctrlOut), 8'h00);
		chk("status", 8'(statusOut), 8'h01);
		chk("sdo", 8'(sdo), 8'h01);
		// One byte, start cleared in mid-byte, then an idle frame
		ctl(2'h2, 1'b1, 1'b0);
		chk("ctrl", 8'(ctrlOut), 8'h05);
		put(8'hA5);
		chk("status", 8'(statusOut), 8'h00);
		kick(4'h2, 8'h3C);
		repeat (3) tick;
		ctl(2'h2, 1'b0, 1'b0);
		chk("active", 8'(statusOut[5:4]), 8'h03);
		finish;
		chk("sent", gotByte, 8'hA5);
		chk("status", 8'(statusOut), 8'h03);
		chk("irq", irqEv, 8'h01);
		kick(4'h0, 8'h77);
		finish;
		chk("idle", gotByte, 8'hFF);
		chk("status", 8'(statusOut), 8'h03);
		get(8'h3C);
		// Load two words while the link stalls, then two bytes back to back
		put(8'hA1);
		put(8'hB2);
		// A1 sits in the hold, B2 in one buffer entry: still room
		chk("txReady", 8'(txReady), 8'h01);
		ctl(2'h2, 1'b1, 1'b0);
		kick(4'h2, 8'h11);
		finish;
		chk("sent", gotByte, 8'hA1);
		get(8'h11);
		kick(4'h0, 8'h22);
		// Stop must cross two link edges before the byte ends
		repeat (2) tick;
		ctl(2'h2, 1'b0, 1'b0);
		finish;
		chk("sent", gotByte, 8'hB2);
		chk("status", 8'(statusOut), 8'h03);
		get(8'h22);
		// Overrun: third byte discarded, no further interrupt
		put(8'hC1);
		put(8'hC2);
		ctl(2'h2, 1'b1, 1'b0);
		kick(4'h2, 8'h41);
		finish;
		kick(4'h0, 8'h42);
		// C3 must reach the hold two link edges before the next byte
		put(8'hC3);
		finish;
		// C3 still waits in the hold, so the empty flag stays low
		chk("status", 8'(statusOut), 8'h26);
		chk("irq", irqEv, 8'h05);
		kick(4'h0, 8'h43);
		repeat (2) tick;
		ctl(2'h2, 1'b0, 1'b0);
		finish;
		chk("irq", irqEv, 8'h05);
		chk("status", 8'(statusOut), 8'h07);
		get(8'h41);
		chk("status", 8'(statusOut), 8'h07);
		get(8'h42);
		chk("status", 8'(statusOut), 8'h01);
		// Underrun: first shift with no data, then read and inhibit
		ctl(2'h2, 1'b1, 1'b0);
		kick(4'h2, 8'h5A);
		repeat (5) tick;
		chk("under", 8'(statusOut.txUnderrun), 8'h01);
		chk("irq", irqEv, 8'h05);
		finish;
		chk("sent", gotByte, 8'hFF);
		chk("irq", irqEv, 8'h06);
		get(8'h5A);
		// Hold plus both entries occupied: writer must stall
		put(8'hE7);
		put(8'hE8);
		put(8'hE9);
		chk("txReady", 8'(txReady), 8'h00);
		ctl(2'h2, 1'b1, 1'b1);
		chk("ctrl", 8'(ctrlOut), 8'h04);
		chk("status", 8'(statusOut), 8'h01);
		get(8'h00);
		kick(4'h0, 8'h00);
		finish;
		chk("idle", gotByte, 8'hFF);
		// Stale run sample at the frame's first edge must not revive any flag
		chk("status", 8'(statusOut), 8'h01);
		chk("irqPulse", irqCnt, irqEv);
		completeRun;
	end
endmodule
`default_nettype wire
